// *** hdl/pseis_map.vh ***
`ifndef PSEIS_MAP_VH
`define PSEIS_MAP_VH
// ****************************************
// command codes
// ****************************************
`define PSEIS_CMD_SUMMARY   8'h00
`define PSEIS_CMD_MASK      8'h01
// ****************************************
// summary bit positions
// ****************************************
`define PSEIS_BIT_SUPPLY    7
`define PSEIS_BIT_START     6
`define PSEIS_BIT_OVERCUR   5
`define PSEIS_BIT_CLASS     4
`define PSEIS_BIT_DETECT    3
`define PSEIS_BIT_DISCON    2
`define PSEIS_BIT_PGOOD     1
`define PSEIS_BIT_PENABLE   0
// ****************************************
// reset values
// ****************************************
`define PSEIS_MASK_RST      8'h80
`define PSEIS_SUMMARY_RST   8'h80
`define PSEIS_ZERO8         8'h00
`define PSEIS_RDATA_RST     8'h00
`define PSEIS_RVALID_RST    1'b0
`define PSEIS_IRQ_IDLE      1'b1
`endif

// *** hdl/pseis_irq_summary.v ***
// Operation
// - supply summary bit7, resets to one
// - start-fault summary bit6 ORs channels
// - overcurrent bit5 ORs cuts and limits
// - class summary bit4 ORs channels
// - detect summary bit3 ORs channels
// - disconnect summary bit2 ORs channels
// - power-good change bit1 ORs channels
// - power-enable change bit0 ORs channels
// - summary active high, read only
// - mask register at code 01h
// - mask zero blocks interrupt
// - summary independent of mask
// - interrupt needs global enable too
// - summary read at code 00h
// - bits clear via event clear-read or reset
// - mask resets with supply bit set
`timescale 1ns/1ns
`include "pseis_map.vh"

module pseis_irq_summary (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  // supply and memory faults
  input  wire       thermal_shutdown,
  input  wire       logic_supply_undervolt,
  input  wire       logic_supply_warning,
  input  wire       power_supply_undervolt,
  input  wire       sram_fault,
  // per-channel and pair flags, bit 0 is channel 1
  input  wire [3:0] start_fault_ch,
  input  wire [3:0] overload_cut_ch,
  input  wire       overload_cut_pair_a,
  input  wire       overload_cut_pair_b,
  input  wire [3:0] current_limit_fault_ch,
  input  wire [3:0] class_cycle_ch,
  input  wire [3:0] detect_cycle_ch,
  input  wire [3:0] disconnect_ch,
  input  wire [3:0] power_good_change_ch,
  input  wire [3:0] power_enable_change_ch,
  // global enable from general mask
  input  wire       global_irq_enable,
  // register command port
  input  wire [7:0] reg_cmd,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  output wire       reg_rvalid,
  // interrupt, active low
  output wire       irq_b
);

  // ****************************************
  // helper functions
  // ****************************************
  // one decode serves the write and the read path
  function pseis_cmd_hit;
    input [7:0] cmd;
    input [7:0] code;
    begin
      pseis_cmd_hit = (cmd == code);
    end
  endfunction

  function pseis_any_flag;
    input [3:0] flags;
    begin
      pseis_any_flag = |flags;
    end
  endfunction

  function pseis_irq_cause;
    input [7:0] status;
    input [7:0] mask;
    input       enable;
    begin
      pseis_irq_cause = enable & (|(status & mask));
    end
  endfunction

  // ****************************************
  // summary bits
  // ****************************************
  // flags are registered upstream and cleared there by clear-on-read or
  // the reset-register command; no copy is kept here, so a clear is seen
  // in the same cycle; an event set in the clear cycle is lost, as the clear wins upstream
  wire       supply_fault_summary;
  wire       start_fault_summary;
  wire       overcurrent_fault_summary;
  wire       class_cycle_summary;
  wire       detect_cycle_summary;
  wire       disconnect_summary;
  wire       power_good_change_summary;
  wire       power_enable_change_summary;

  assign supply_fault_summary = thermal_shutdown
    | logic_supply_undervolt
    | logic_supply_warning
    | power_supply_undervolt
    | sram_fault;
  assign start_fault_summary = pseis_any_flag(start_fault_ch);
  assign overcurrent_fault_summary = pseis_any_flag(overload_cut_ch)
    | overload_cut_pair_a
    | overload_cut_pair_b
    | pseis_any_flag(current_limit_fault_ch);
  assign class_cycle_summary = pseis_any_flag(class_cycle_ch);
  assign detect_cycle_summary = pseis_any_flag(detect_cycle_ch);
  assign disconnect_summary = pseis_any_flag(disconnect_ch);
  assign power_good_change_summary =
    pseis_any_flag(power_good_change_ch);
  assign power_enable_change_summary =
    pseis_any_flag(power_enable_change_ch);

  reg  [7:0] summary;
  always @* begin
    summary = `PSEIS_ZERO8;
    summary[`PSEIS_BIT_SUPPLY]  = supply_fault_summary;
    summary[`PSEIS_BIT_START]   = start_fault_summary;
    summary[`PSEIS_BIT_OVERCUR] = overcurrent_fault_summary;
    summary[`PSEIS_BIT_CLASS]   = class_cycle_summary;
    summary[`PSEIS_BIT_DETECT]  = detect_cycle_summary;
    summary[`PSEIS_BIT_DISCON]  = disconnect_summary;
    summary[`PSEIS_BIT_PGOOD]   = power_good_change_summary;
    summary[`PSEIS_BIT_PENABLE] = power_enable_change_summary;
  end

  // ****************************************
  // mask register
  // ****************************************
  wire       mask_wr;
  reg  [7:0] irq_mask_d;
  reg  [7:0] irq_mask_q;

  assign mask_wr = reg_wr & pseis_cmd_hit(reg_cmd, `PSEIS_CMD_MASK);

  always @* begin
    irq_mask_d = irq_mask_q;
    if (mask_wr) begin
      irq_mask_d = reg_wdata;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= `PSEIS_MASK_RST;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  wire       summary_rd;
  wire       mask_rd;
  reg  [7:0] reg_rdata_d;
  reg  [7:0] reg_rdata_q;
  reg        reg_rvalid_d;
  reg        reg_rvalid_q;

  assign summary_rd = reg_rd & pseis_cmd_hit(reg_cmd, `PSEIS_CMD_SUMMARY);
  assign mask_rd    = reg_rd & pseis_cmd_hit(reg_cmd, `PSEIS_CMD_MASK);

  // writes to the summary code are ignored: status is read only;
  // read data holds between reads so a slow host may sample it late
  always @* begin
    reg_rvalid_d = reg_rd;
    reg_rdata_d  = reg_rdata_q;
    if (summary_rd) begin
      reg_rdata_d = summary;
    end else if (mask_rd) begin
      reg_rdata_d = irq_mask_q;
    end else if (reg_rd) begin
      reg_rdata_d = `PSEIS_ZERO8;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= `PSEIS_RDATA_RST;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rvalid_q <= `PSEIS_RVALID_RST;
    end else begin
      reg_rvalid_q <= reg_rvalid_d;
    end
  end

  // ****************************************
  // interrupt output
  // ****************************************
  wire       irq_cause;
  reg        irq_b_d;
  reg        irq_b_q;

  // mask gates only the pin, not the summary
  assign irq_cause = pseis_irq_cause(summary, irq_mask_q,
                                     global_irq_enable);

  // registered so the pin is glitch free; costs one cycle of latency
  always @* begin
    irq_b_d = ~irq_cause;
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b_q <= `PSEIS_IRQ_IDLE;
    end else begin
      irq_b_q <= irq_b_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata  = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;
  assign irq_b      = irq_b_q;

endmodule // pseis_irq_summary

// *** test/pseis_flag_model.sv ***
`timescale 1ns/1ns
module pseis_flag_model (
  input  wire        core_clk, rst_b, clr,
  input  wire [38:0] set_v,
  output reg  [38:0] flags_q
);
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b) flags_q <= 39'h1;
    else flags_q <= clr ? 39'h0 : flags_q | set_v;
endmodule // pseis_flag_model

// *** test/pseis_irq_summary_sva.sv ***
`timescale 1ns/1ns
module pseis_irq_summary_sva (
  input wire       core_clk, rst_b, reg_wr, reg_rd, reg_rvalid, irq_b,
  input wire       global_irq_enable,
  input wire [7:0] reg_cmd, reg_wdata, reg_rdata,
  input wire       thermal_shutdown, logic_supply_undervolt,
  input wire       logic_supply_warning, power_supply_undervolt, sram_fault,
  input wire       overload_cut_pair_a, overload_cut_pair_b,
  input wire [3:0] start_fault_ch, overload_cut_ch, current_limit_fault_ch,
  input wire [3:0] class_cycle_ch, detect_cycle_ch, disconnect_ch,
  input wire [3:0] power_good_change_ch, power_enable_change_ch
);
  reg [7:0] mask_q;
  wire [7:0] sum_w = {thermal_shutdown | logic_supply_undervolt |
    logic_supply_warning | power_supply_undervolt | sram_fault,
    |start_fault_ch, |{overload_cut_ch, overload_cut_pair_a,
    overload_cut_pair_b, current_limit_fault_ch}, |class_cycle_ch,
    |detect_cycle_ch, |disconnect_ch, |power_good_change_ch,
    |power_enable_change_ch};
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b) mask_q <= 8'h80;
    else if (reg_wr && reg_cmd == 8'h01) mask_q <= reg_wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_rd_mask: assert property (reg_rd && reg_cmd == 8'h01 |=>
    reg_rdata == $past(mask_q)) else $error("mask read");
  chk_rd_other: assert property (reg_rd && reg_cmd > 8'h01 |=>
    reg_rdata == 8'h00) else $error("unmapped read");
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("no read answer");
  chk_rv_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("stray answer");
  chk_en_gate: assert property (!global_irq_enable |=> irq_b)
    else $error("irq without enable");
  chk_mask_zero: assert property (mask_q == 8'h00 |=> irq_b)
    else $error("irq with all masked");
  chk_fall_en: assert property ($fell(irq_b) |-> $past(global_irq_enable))
    else $error("irq fell while disabled");
  chk_rd_hold: assert property (!reg_rd ##1 !reg_rd |=>
    $stable(reg_rdata)) else $error("read data moved");
  chk_rd_summary: assert property (reg_rd && reg_cmd == 8'h00 |=>
    reg_rdata == $past(sum_w)) else $error("summary read");
  chk_irq_follow: assert property (1'b1 |=>
    irq_b == !$past(global_irq_enable && (|(sum_w & mask_q))))
    else $error("irq level wrong");
endmodule // pseis_irq_summary_sva
bind pseis_irq_summary pseis_irq_summary_sva pseis_irq_summary_sva_inst (
  .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .irq_b(irq_b),
  .global_irq_enable(global_irq_enable), .reg_cmd(reg_cmd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .thermal_shutdown(thermal_shutdown),
  .logic_supply_undervolt(logic_supply_undervolt),
  .logic_supply_warning(logic_supply_warning),
  .power_supply_undervolt(power_supply_undervolt), .sram_fault(sram_fault),
  .overload_cut_pair_a(overload_cut_pair_a),
  .overload_cut_pair_b(overload_cut_pair_b),
  .start_fault_ch(start_fault_ch), .overload_cut_ch(overload_cut_ch),
  .current_limit_fault_ch(current_limit_fault_ch),
  .class_cycle_ch(class_cycle_ch), .detect_cycle_ch(detect_cycle_ch),
  .disconnect_ch(disconnect_ch), .power_good_change_ch(power_good_change_ch),
  .power_enable_change_ch(power_enable_change_ch));

// *** test/pseis_irq_summary_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h", $time, a); end end
module pseis_irq_summary_tb_top;
  reg core_clk = 0, rst_b = 0, en = 1, reg_wr = 0, reg_rd = 0, clr = 0;
  reg  [7:0]  reg_cmd = 8'h00, reg_wdata = 8'h00;
  reg  [38:0] set_v = 39'h0;
  wire [38:0] f;
  wire [7:0]  reg_rdata;
  wire        reg_rvalid, irq_b;
  int mismatches = 0, n_tests = 0, idx[8] = '{38, 34, 30, 26, 22, 14, 8, 4};
  pseis_irq_summary pseis_irq_summary_inst (.core_clk, .rst_b,
    .thermal_shutdown(f[0]), .logic_supply_undervolt(f[1]),
    .logic_supply_warning(f[2]), .power_supply_undervolt(f[3]),
    .sram_fault(f[4]), .start_fault_ch(f[8:5]), .overload_cut_ch(f[12:9]),
    .overload_cut_pair_a(f[13]), .overload_cut_pair_b(f[14]),
    .current_limit_fault_ch(f[18:15]), .class_cycle_ch(f[22:19]),
    .detect_cycle_ch(f[26:23]), .disconnect_ch(f[30:27]),
    .power_good_change_ch(f[34:31]), .power_enable_change_ch(f[38:35]),
    .global_irq_enable(en), .reg_cmd, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .irq_b);
  pseis_flag_model pseis_flag_model_inst (.core_clk, .rst_b, .clr, .set_v,
    .flags_q(f));
  task automatic wr(input [7:0] c, d);
    @(negedge core_clk) {reg_wr, reg_cmd, reg_wdata} = {1'b1, c, d};
    @(negedge core_clk) reg_wr = 0;
  endtask
  task automatic rd(input [7:0] c, e);
    @(negedge core_clk) {reg_rd, reg_cmd} = {1'b1, c};
    @(negedge core_clk) reg_rd = 0;
    `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
  endtask
  task automatic irq(input e);
    repeat (2) @(negedge core_clk);
    `CHK(irq_b, e)
  endtask
  function automatic int grp(input int b);
    return b < 5 ? 7 : b < 9 ? 6 : b < 19 ? 5 : b < 23 ? 4 :
      b < 27 ? 3 : b < 31 ? 2 : b < 35 ? 1 : 0;
  endfunction
  task automatic pulse(input [38:0] s, input c);
    @(negedge core_clk) {set_v, clr} = {s, c};
    @(negedge core_clk) {set_v, clr} = 40'h0;
  endtask
  task finish_test;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #5 core_clk = ~core_clk;
  initial begin #200000; mismatches++; finish_test; end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1;
    irq(0);
    rd(8'h00, 8'h80);
    wr(8'h00, 8'hFF);
    rd(8'h01, 8'h80);
    rd(8'h07, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, 8'h00);
      pulse(39'h0, 1'b1);
      rd(8'h00, 8'h00);
      pulse(39'h1 << idx[i], 1'b0);
      rd(8'h00, 8'h01 << i);
      irq(1);
      wr(8'h01, 8'h01 << i);
      rd(8'h01, 8'h01 << i);
      irq(0);
      en = 0;
      irq(1);
      en = 1;
      pulse(39'h0, 1'b1);
      irq(1);
    end
    for (int b = 0; b < 39; b++) begin
      pulse(39'h0, 1'b1);
      pulse(39'h1 << b, 1'b0);
      rd(8'h00, 8'h01 << grp(b));
    end
    finish_test;
  end
endmodule // pseis_irq_summary_tb_top
